/* shared/psl_pkg.sv */
// constants and types of the pixel serial link framer
// Functional notes
// RL1 - 24 data and 3 control bits per pixel clock on one pair, 280M to 2.1G
// RL2 - each pixel period holds 28 serial bit intervals
// RL3 - each frame has a fixed high and a fixed low clock bit
// RL4 - payload positions carry scrambled pixel data; compatible modes send it unscrambled
// RL5 - balance flag sends payload plain or inverted; receiver undoes it
// RL6 - integrity bit validates frames and carries encoded sync and enable
// RL7 - control bits travel encoded, never as payload bits
// RL8 - receiver locks on arbitrary data, no reference or training
// RL9 - all lanes and all 27 bit positions are always sampled
// RL10 - map pin high puts MSBs on lane 3, low puts LSBs there
// RL11 - a control register may choose the lane map instead of the pin
// RL12 - mode pins: LL normal, LH normal filtered, HL and HH compatible
// RL13 - compatible modes by pins only; filter by pin or register
// RL14 - disabling the serial output drops receiver lock until relock
// RL15 - encode order is scramble, then balance, then shuffle
// RL16 - control bit 24 hsync, 25 vsync, 26 data enable
// RL17 - at most 2 enable or hsync, 1 vsync transitions per 130 clocks
// RL18 - filter on drops enable and hsync pulses under 3 clocks
// RL19 - missing clock bits drop lock; outputs hold until relock
package psl_pkg;
    localparam int PSL_FRAME_W = 28;
    localparam int PSL_DATA_W = 24;
    localparam int PSL_CTL_W = 3;
    localparam int PSL_WORD_W = 27;
    localparam int PSL_LANE_W = 7;
    localparam int PSL_LANE_BITS = 28;
    localparam int PSL_RATE_MIN_MBPS = 280;
    localparam int PSL_RATE_MAX_MBPS = 2100;
    localparam int PSL_POS_CLK_HI = 27;
    localparam int PSL_POS_DCB = 26;
    localparam int PSL_POS_DCA = 25;
    localparam int PSL_POS_PAY = 1;
    localparam int PSL_POS_CLK_LO = 0;
    localparam int PSL_CTL_VS = 1;
    localparam int PSL_LANE0_DATA = 3;
    localparam int PSL_SHUF_STEP = 7;
    localparam int PSL_CTL_WIN = 130;
    localparam logic [1:0] PSL_LIM_DE_HS = 2'h2;
    localparam logic [1:0] PSL_LIM_VS = 2'h1;
    localparam logic [1:0] PSL_GLITCH_MIN = 2'h3;
    localparam logic [3:0] PSL_LOCK_MARKS = 4'h8;
    localparam logic [1:0] PSL_MARK_SLOT = 2'h3;
    localparam int PSL_DISP_W = 8;
    localparam logic [7:0] PSL_REG_CTRL = 8'h00;
    localparam logic [7:0] PSL_REG_STATUS = 8'h04;
    localparam logic [7:0] PSL_REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] PSL_REG_IRQ_MASK = 8'h0C;
    localparam int PSL_CTRL_W = 4;
    localparam int PSL_CTRL_MAP_OVR = 0;
    localparam int PSL_CTRL_MAP_VAL = 1;
    localparam int PSL_CTRL_FILT_EN = 2;
    localparam int PSL_CTRL_TX_EN = 3;
    localparam logic [3:0] PSL_CTRL_RST = 4'h8;
    localparam int PSL_IRQ_W = 4;
    localparam int PSL_IRQ_LOCK_UP = 0;
    localparam int PSL_IRQ_LOCK_LOST = 1;
    localparam int PSL_IRQ_CTL_DROP = 2;
    localparam int PSL_IRQ_INTEG = 3;
    typedef enum logic [1:0] {
        PSL_MODE_NORMAL = 2'b00,
        PSL_MODE_FILTER = 2'b01,
        PSL_MODE_COMPAT_A = 2'b10,
        PSL_MODE_COMPAT_B = 2'b11
    } psl_mode_e;
    typedef enum logic [1:0] {
        PSL_RX_HUNT = 2'b00,
        PSL_RX_CHECK = 2'b01,
        PSL_RX_LOCKED = 2'b10
    } psl_rx_e;
endpackage : psl_pkg

/* hw/psl_ctl_filter.sv */
// glitch filter and transition limiter for the three control bits
`timescale 1ns/1ns
module psl_ctl_filter import psl_pkg::*; (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // control bits
    input  wire logic [PSL_CTL_W-1:0] ctl_in,
    input  wire logic                 filter_en,
    output logic      [PSL_CTL_W-1:0] ctl_out,
    output logic                      ctl_drop
);
    typedef struct packed {
        logic       out;
        logic       cand;
        logic [1:0] stab;
        logic [1:0] trans;
    } psl_ch_s;
    typedef struct packed {
        psl_ch_s [PSL_CTL_W-1:0] ch;
        logic [7:0]              win;
        logic                    drop;
    } psl_filt_s;
    psl_filt_s s_reg, s_next;
    psl_ch_s   ch_nx [PSL_CTL_W];
    logic      drop_nx [PSL_CTL_W];
    logic      win_end;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    assign win_end = (s_reg.win == 8'(PSL_CTL_WIN - 1));
    assign ctl_drop = s_reg.drop;

    for (genvar i = 0; i < PSL_CTL_W; i++) begin : g_ch
        localparam logic [1:0] LIM = (i == PSL_CTL_VS) ? PSL_LIM_VS : PSL_LIM_DE_HS;
        always_comb begin
            psl_ch_s c;
            c = s_reg.ch[i];
            drop_nx[i] = 1'b0;
            if (ctl_in[i] != c.cand) begin
                drop_nx[i] = (c.cand != c.out);
                c.cand = ctl_in[i];
                c.stab = 2'h1;
            end else if (c.stab != PSL_GLITCH_MIN) begin
                c.stab = c.stab + 2'h1;
            end
            if (win_end) begin
                c.trans = 2'h0;
            end
            if (c.cand != c.out && (!filter_en || c.stab == PSL_GLITCH_MIN)
                    && c.trans != LIM) begin // see RL17 see RL18
                c.out = c.cand;
                c.trans = c.trans + 2'h1;
            end
            ch_nx[i] = c;
        end
        assign ctl_out[i] = s_reg.ch[i].out;

        a_rate_limit: assert property (s_reg.ch[i].trans <= LIM) // see RL17
            else $error("control transitions exceed window limit");
        a_glitch_reject: assert property ((ce && $past(ce) && $past(ce, 2) && filter_en
            && ch_nx[i].out != s_reg.ch[i].out)
            |-> ($past(ctl_in[i]) == ctl_in[i] && $past(ctl_in[i], 2) == ctl_in[i])) // see RL18
            else $error("short control pulse passed the filter");
    end

    always_comb begin
        s_next = s_reg;
        s_next.drop = 1'b0;
        if (ce) begin
            s_next.win = win_end ? 8'h00 : s_reg.win + 8'h01;
            for (int k = 0; k < PSL_CTL_W; k++) begin
                s_next.ch[k] = ch_nx[k];
                s_next.drop = s_next.drop | drop_nx[k];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    c_ctl_drop: cover property (s_reg.drop);
endmodule : psl_ctl_filter

/* hw/psl_dc_balance.sv */
// running disparity tracker choosing plain or inverted payload
`timescale 1ns/1ns
module psl_dc_balance import psl_pkg::*; (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // payload word
    input  wire logic [PSL_DATA_W-1:0] word,
    input  wire logic                  advance,
    output logic                       invert
);
    typedef struct packed {
        logic signed [PSL_DISP_W-1:0] disp;
    } psl_bal_s;
    psl_bal_s s_reg, s_next;
    logic [4:0] ones;
    logic signed [PSL_DISP_W-1:0] bias;
    localparam logic signed [PSL_DISP_W-1:0] HALF = PSL_DISP_W'(PSL_DATA_W);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    always_comb begin
        ones = 5'h00;
        for (int b = 0; b < PSL_DATA_W; b++) begin
            ones = ones + 5'(word[b]);
        end
        bias = $signed({2'h0, ones, 1'b0}) - HALF;
        invert = (s_reg.disp != 0) && (bias != 0)
            && (s_reg.disp[PSL_DISP_W-1] == bias[PSL_DISP_W-1]); // see RL5
        s_next = s_reg;
        if (ce && advance) begin
            s_next.disp = invert ? s_reg.disp - bias : s_reg.disp + bias;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    a_disp_bound: assert property (s_reg.disp <= HALF && s_reg.disp >= -HALF) // see RL5
        else $error("line disparity out of bound");
    c_invert: cover property (ce && advance && invert);
endmodule : psl_dc_balance

/* hw/psl_framer.sv */
// serializer framing, deserializer lock and configuration of the link
`timescale 1ns/1ns
module psl_framer import psl_pkg::*; (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // parallel input lanes and strap pins
    input  wire logic [PSL_LANE_BITS-1:0] tx_lanes,
    input  wire logic                     lane_map_select,
    input  wire logic [1:0]               config_mode,
    // serial frame out
    output logic      [PSL_FRAME_W-1:0]   serial_frame_out,
    output logic                          serial_frame_oe,
    // serial frame in and parallel output lanes
    input  wire logic [PSL_FRAME_W-1:0]   serial_frame_in,
    output logic      [PSL_LANE_BITS-1:0] rx_lanes,
    output logic                          rx_locked,
    // register port
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    // interrupt
    output logic                          irq
);
    localparam int PIN_W = PSL_LANE_BITS + 3;

    typedef struct packed {
        logic [PIN_W-1:0]         pin_a;
        logic [PIN_W-1:0]         pin_b;
        logic [PSL_FRAME_W-1:0]   rxf_a;
        logic [PSL_FRAME_W-1:0]   rxf_b;
        logic [PSL_CTRL_W-1:0]    ctrl;
        logic [PSL_IRQ_W-1:0]     irq_stat;
        logic [PSL_IRQ_W-1:0]     irq_mask;
        logic [31:0]              rdata;
        logic [PSL_DATA_W-1:0]    tx_prev;
        logic [1:0]               tx_slot;
        logic [PSL_CTL_W-1:0]     tx_ctl;
        logic [PSL_FRAME_W-1:0]   frame;
        logic                     oe;
        psl_rx_e                  rx_state;
        logic [3:0]               rx_marks;
        logic [1:0]               rx_slot;
        logic [PSL_DATA_W-1:0]    rx_prev;
        logic [PSL_CTL_W-1:0]     rx_acc;
        logic [PSL_CTL_W-1:0]     rx_ctl;
        logic [PSL_LANE_BITS-1:0] rx_out;
    } psl_state_s;
    psl_state_s s_reg, s_next;

    // lanes to {ctl, data}; msb_hi puts data MSBs on lane 3
    function automatic logic [PSL_WORD_W-1:0] lanes_to_word(
        input logic [PSL_LANE_BITS-1:0] ln,
        input logic                     msb_hi);
        logic [PSL_DATA_W-1:0] d;
        d = '0;
        for (int j = 1; j < 4; j++) begin
            if (msb_hi) begin
                d[PSL_LANE0_DATA + (j - 1) * PSL_LANE_W +: PSL_LANE_W] = ln[j * PSL_LANE_W +: PSL_LANE_W];
            end else begin
                d[(3 - j) * PSL_LANE_W +: PSL_LANE_W] = ln[j * PSL_LANE_W +: PSL_LANE_W];
            end
        end
        if (msb_hi) begin
            d[PSL_LANE0_DATA-1:0] = ln[PSL_LANE0_DATA-1:0];
        end else begin
            d[PSL_DATA_W-1 -: PSL_LANE0_DATA] = ln[PSL_LANE0_DATA-1:0];
        end
        return {ln[PSL_LANE0_DATA +: PSL_CTL_W], d}; // see RL16
    endfunction : lanes_to_word

    function automatic logic [PSL_LANE_BITS-1:0] word_to_lanes(
        input logic [PSL_WORD_W-1:0] w,
        input logic                  msb_hi);
        logic [PSL_LANE_BITS-1:0] ln;
        ln = '0;
        for (int j = 1; j < 4; j++) begin
            if (msb_hi) begin
                ln[j * PSL_LANE_W +: PSL_LANE_W] = w[PSL_LANE0_DATA + (j - 1) * PSL_LANE_W +: PSL_LANE_W];
            end else begin
                ln[j * PSL_LANE_W +: PSL_LANE_W] = w[(3 - j) * PSL_LANE_W +: PSL_LANE_W];
            end
        end
        ln[PSL_LANE0_DATA-1:0] = msb_hi ? w[PSL_LANE0_DATA-1:0]
                                        : w[PSL_DATA_W-1 -: PSL_LANE0_DATA];
        ln[PSL_LANE0_DATA +: PSL_CTL_W] = w[PSL_DATA_W +: PSL_CTL_W];
        return ln;
    endfunction : word_to_lanes

    function automatic logic [PSL_DATA_W-1:0] shuffle(input logic [PSL_DATA_W-1:0] v,
                                                     input logic fwd);
        logic [PSL_DATA_W-1:0] o;
        o = '0;
        for (int i = 0; i < PSL_DATA_W; i++) begin
            if (fwd) begin
                o[(i * PSL_SHUF_STEP) % PSL_DATA_W] = v[i];
            end else begin
                o[i] = v[(i * PSL_SHUF_STEP) % PSL_DATA_W];
            end
        end
        return o;
    endfunction : shuffle

    function automatic logic [PSL_DATA_W-1:0] rot(input logic [PSL_DATA_W-1:0] v);
        return {v[0], v[PSL_DATA_W-1:1]};
    endfunction : rot

    logic [PSL_LANE_BITS-1:0] tx_ln;
    logic                     map_pin;
    psl_mode_e                mode;
    logic                     compat;
    logic                     filt_use;
    logic                     map_use;
    logic [PSL_WORD_W-1:0]    tx_word;
    logic [PSL_DATA_W-1:0]    scr;
    logic                     invert;
    logic [PSL_DATA_W-1:0]    shuf;
    logic [PSL_CTL_W-1:0]     filt_ctl;
    logic                     ctl_drop;
    logic                     ctl_bit;
    logic                     dca;
    logic [PSL_FRAME_W-1:0]   rf;
    logic                     clk_ok;
    logic [PSL_DATA_W-1:0]    rpay;
    logic                     rx_x;
    logic [PSL_DATA_W-1:0]    rs;
    logic [PSL_DATA_W-1:0]    rd;
    logic                     mark_bad;
    logic [4:0]               status;

    // all lanes and straps are sampled every clock
    assign tx_ln = s_reg.pin_b[PSL_LANE_BITS-1:0]; // see RL9
    assign map_pin = s_reg.pin_b[PSL_LANE_BITS];
    assign mode = psl_mode_e'(s_reg.pin_b[PIN_W-1 -: 2]); // see RL12
    assign compat = (mode == PSL_MODE_COMPAT_A) || (mode == PSL_MODE_COMPAT_B); // see RL13
    assign filt_use = !compat && (mode == PSL_MODE_FILTER || s_reg.ctrl[PSL_CTRL_FILT_EN]); // see RL13
    assign map_use = s_reg.ctrl[PSL_CTRL_MAP_OVR] ? s_reg.ctrl[PSL_CTRL_MAP_VAL] : map_pin; // see RL10 see RL11
    assign tx_word = lanes_to_word(tx_ln, map_use);
    // scramble, balance, shuffle
    assign scr = compat ? tx_word[PSL_DATA_W-1:0]
                        : tx_word[PSL_DATA_W-1:0] ^ rot(s_reg.tx_prev); // see RL4 see RL15
    assign shuf = shuffle(invert ? ~scr : scr, 1'b1); // see RL15
    // control bits ride the integrity bit, one per slot, slot 3 is the marker
    assign ctl_bit = (s_reg.tx_slot == PSL_MARK_SLOT) ? 1'b1 : s_reg.tx_ctl[s_reg.tx_slot]; // see RL7
    assign dca = ^{shuf, invert} ^ ctl_bit; // see RL6

    assign rf = s_reg.rxf_b;
    assign clk_ok = rf[PSL_POS_CLK_HI] && !rf[PSL_POS_CLK_LO]; // see RL19
    assign rpay = rf[PSL_POS_PAY +: PSL_DATA_W];
    assign rx_x = rf[PSL_POS_DCA] ^ ^{rpay, rf[PSL_POS_DCB]};
    assign rs = rf[PSL_POS_DCB] ? ~shuffle(rpay, 1'b0) : shuffle(rpay, 1'b0); // see RL5
    assign rd = compat ? rs : rs ^ rot(s_reg.rx_prev); // see RL8
    assign mark_bad = (s_reg.rx_slot == PSL_MARK_SLOT) && !rx_x; // see RL6
    assign status = {filt_use, map_use, mode, rx_locked};

    psl_ctl_filter u_filter (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .ctl_in    (tx_word[PSL_DATA_W +: PSL_CTL_W]),
        .filter_en (filt_use),
        .ctl_out   (filt_ctl),
        .ctl_drop  (ctl_drop)
    );

    psl_dc_balance u_balance (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .word    (scr),
        .advance (s_reg.ctrl[PSL_CTRL_TX_EN]),
        .invert  (invert)
    );

    always_comb begin
        logic [PSL_IRQ_W-1:0] ev;
        ev = '0;
        s_next = s_reg;
        if (ce) begin
            s_next.rdata = '0;
            s_next.pin_a = {config_mode, lane_map_select, tx_lanes};
            s_next.pin_b = s_reg.pin_a;
            s_next.rxf_a = serial_frame_in;
            s_next.rxf_b = s_reg.rxf_a;
            if (reg_wr) begin
                case (reg_addr)
                    PSL_REG_CTRL: begin
                        s_next.ctrl = reg_wdata[PSL_CTRL_W-1:0];
                    end
                    PSL_REG_IRQ_STAT: begin
                        s_next.irq_stat = s_reg.irq_stat & ~reg_wdata[PSL_IRQ_W-1:0];
                    end
                    PSL_REG_IRQ_MASK: begin
                        s_next.irq_mask = reg_wdata[PSL_IRQ_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    PSL_REG_CTRL: s_next.rdata = 32'(s_reg.ctrl);
                    PSL_REG_STATUS: s_next.rdata = 32'(status);
                    PSL_REG_IRQ_STAT: s_next.rdata = 32'(s_reg.irq_stat);
                    PSL_REG_IRQ_MASK: s_next.rdata = 32'(s_reg.irq_mask);
                    default: s_next.rdata = '0;
                endcase
            end
            // serializer: one 28-bit frame per pixel clock
            s_next.tx_prev = scr;
            s_next.tx_slot = s_reg.tx_slot + 2'h1;
            if (s_reg.tx_slot == PSL_MARK_SLOT) begin
                s_next.tx_ctl = filt_ctl;
            end
            s_next.oe = s_next.ctrl[PSL_CTRL_TX_EN]; // see RL14
            s_next.frame = s_next.ctrl[PSL_CTRL_TX_EN]
                ? {1'b1, invert, dca, shuf, 1'b0} : '0; // see RL1 see RL2 see RL3
            // deserializer lock
            s_next.rx_prev = rs;
            s_next.rx_slot = s_reg.rx_slot + 2'h1;
            case (s_reg.rx_state)
                PSL_RX_HUNT: begin
                    if (clk_ok && rx_x) begin // see RL8
                        s_next.rx_state = PSL_RX_CHECK;
                        s_next.rx_marks = 4'h0;
                        s_next.rx_slot = 2'h0;
                    end
                end
                PSL_RX_CHECK: begin
                    if (!clk_ok || mark_bad) begin
                        s_next.rx_state = PSL_RX_HUNT;
                    end else if (s_reg.rx_slot == PSL_MARK_SLOT) begin
                        s_next.rx_marks = s_reg.rx_marks + 4'h1;
                        if (s_reg.rx_marks == PSL_LOCK_MARKS - 4'h1) begin
                            s_next.rx_state = PSL_RX_LOCKED;
                            ev[PSL_IRQ_LOCK_UP] = 1'b1;
                        end
                    end
                end
                PSL_RX_LOCKED: begin
                    if (!clk_ok || mark_bad) begin // see RL14 see RL19
                        s_next.rx_state = PSL_RX_HUNT;
                        ev[PSL_IRQ_LOCK_LOST] = 1'b1;
                        ev[PSL_IRQ_INTEG] = clk_ok;
                    end else begin
                        if (s_reg.rx_slot == PSL_MARK_SLOT) begin
                            s_next.rx_ctl = s_reg.rx_acc;
                        end else begin
                            s_next.rx_acc[s_reg.rx_slot] = rx_x; // see RL7
                        end
                        s_next.rx_out = word_to_lanes({s_reg.rx_ctl, rd}, map_use);
                    end
                end
                default: begin
                    s_next.rx_state = PSL_RX_HUNT;
                end
            endcase
            ev[PSL_IRQ_CTL_DROP] = ctl_drop;
            s_next.irq_stat = s_next.irq_stat | ev;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.ctrl <= PSL_CTRL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign serial_frame_out = s_reg.frame;
    assign serial_frame_oe = s_reg.oe;
    assign rx_lanes = s_reg.rx_out;
    assign rx_locked = (s_reg.rx_state == PSL_RX_LOCKED);
    assign reg_rdata = s_reg.rdata;
    assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_clock_bits: assert property (serial_frame_oe
        |-> serial_frame_out[PSL_POS_CLK_HI] && !serial_frame_out[PSL_POS_CLK_LO]) // see RL3
        else $error("frame clock bits wrong");
    a_tx_disable: assert property ((ce && reg_wr && reg_addr == PSL_REG_CTRL
        && !reg_wdata[PSL_CTRL_TX_EN]) |=> !serial_frame_oe && serial_frame_out == '0) // see RL14
        else $error("serial output not disabled");
    a_marker_slot: assert property ((ce && s_reg.tx_slot == PSL_MARK_SLOT) |=> !serial_frame_oe
        || serial_frame_out[PSL_POS_DCA] == !(^{serial_frame_out[PSL_POS_DCB],
        serial_frame_out[PSL_POS_DCA-1:PSL_POS_PAY]})) // see RL6
        else $error("marker slot integrity bit wrong");
    a_scramble_on: assert property ((!compat && s_reg.tx_prev != '0)
        |-> scr != tx_word[PSL_DATA_W-1:0]) // see RL4
        else $error("payload not scrambled");
    a_map_pin: assert property ((ce && $past(ce) && $past(ce, 2)
        && !s_reg.ctrl[PSL_CTRL_MAP_OVR] && !$past(s_reg.ctrl[PSL_CTRL_MAP_OVR], 2))
        |-> map_use == $past(lane_map_select, 2)) // see RL10
        else $error("lane map does not follow pin");
    a_map_reg: assert property (s_reg.ctrl[PSL_CTRL_MAP_OVR]
        |-> map_use == s_reg.ctrl[PSL_CTRL_MAP_VAL]) // see RL11
        else $error("lane map does not follow register");
    a_compat_filter: assert property (s_reg.pin_b[PIN_W-1] |-> !filt_use) // see RL13
        else $error("filter active in compatible mode");
    a_lock_drop: assert property ((ce && rx_locked && !clk_ok)
        |=> !rx_locked && s_reg.irq_stat[PSL_IRQ_LOCK_LOST]) // see RL19
        else $error("lock kept without clock bits");
    a_hold_out: assert property ((ce && !rx_locked) |=> $stable(rx_lanes)) // see RL19
        else $error("outputs moved while unlocked");

    c_lock_up: cover property ($rose(rx_locked));
    c_lock_lost: cover property ($fell(rx_locked));
    c_irq: cover property (irq && s_reg.irq_stat[PSL_IRQ_CTL_DROP]);
endmodule : psl_framer

/* testbench/psl_link_partner.sv */
// far-side model: deserializer wire looped back, with released and broken link
`timescale 1ns/1ns
module psl_link_partner import psl_pkg::*; (
    // link
    input  wire logic [PSL_FRAME_W-1:0] frame_out,
    input  wire logic                   frame_oe,
    input  wire logic                   break_clk,
    output logic      [PSL_FRAME_W-1:0] frame_in
);
    always_comb begin
        if (frame_oe && !break_clk) begin
            frame_in = frame_out;
        end else begin
            frame_in = ~frame_out;
        end
    end
endmodule : psl_link_partner

/* testbench/testbench.sv */
// self-checking bench of the framer looped through the partner model
`timescale 1ns/1ns
module testbench import psl_pkg::*; ;
    logic        clk, rst_n, brk, reg_wr, reg_rd, lms, soe, rxl, irq;
    logic [1:0]  cm;
    logic [27:0] tx, rx, sfo, sfi, t;
    logic [7:0]  ra;
    logic [31:0] wd, rdv, v;
    int          mismatches, n_checks;
    psl_framer i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .tx_lanes(tx),
        .lane_map_select(lms), .config_mode(cm), .serial_frame_out(sfo),
        .serial_frame_oe(soe), .serial_frame_in(sfi), .rx_lanes(rx), .rx_locked(rxl),
        .reg_addr(ra), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdv), .irq(irq));
    psl_link_partner i_far (.frame_out(sfo), .frame_oe(soe), .break_clk(brk),
        .frame_in(sfi));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic complete_run();
        $display("mismatches %0d checks %0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin ra <= a; wd <= d; reg_wr <= 1'b1; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) begin ra <= a; reg_rd <= 1'b1; end
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = rdv;
    endtask : rd
    task automatic wait_lock(input logic e);
        int i;
        for (i = 0; i < 400 && rxl !== e; i++) @(posedge clk);
        check("rx_locked", rxl, e);
        if (rxl !== e) complete_run();
    endtask : wait_lock
    initial begin
        {rst_n, brk, reg_wr, reg_rd, lms, cm, tx, ra, wd} = '0;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(97));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(PSL_REG_CTRL, v);
        check("ctrl reset", v, 32'h8);
        rd(8'h10, v);
        check("unmapped", v, 32'h0);
        wr(PSL_REG_IRQ_MASK, 32'h3);
        for (int m = 0; m < 4; m++) begin
            t = $urandom;
            t[5:3] = 3'(m);
            cm <= 2'(m);
            lms <= t[27];
            tx <= t;
            repeat (12) @(posedge clk);
            wait_lock(1'b1);
            repeat (140) @(posedge clk);
            check("frame clock", {sfo[27], sfo[0]}, 32'h2);
            check("rx_lanes", rx, t & ~28'h40);
            rd(PSL_REG_STATUS, v);
            check("status", v, {27'h0, m == 1, t[27], 2'(m), 1'b1});
        end
        lms <= 1'b0;
        wr(PSL_REG_CTRL, 32'hF);
        rd(PSL_REG_STATUS, v);
        check("map by register", v[4:3], 32'h1);
        check("irq lock up", irq, 1'b1);
        wr(PSL_REG_IRQ_STAT, 32'hF);
        @(posedge clk);
        check("irq cleared", irq, 1'b0);
        brk <= 1'b1;
        wait_lock(1'b0);
        rd(PSL_REG_IRQ_STAT, v);
        check("lock lost flag", v[1], 1'b1);
        brk <= 1'b0;
        wait_lock(1'b1);
        wr(PSL_REG_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        check("oe off", {soe, sfo}, 32'h0);
        wait_lock(1'b0);
        complete_run();
    end
endmodule : testbench
